// *** pkg/psq_pkg.sv ***
// power and reset sequencer constants: clock rate, timing windows, states
// assumes a 125 MHz system clock; all long waits are counted in microseconds
package psq_pkg;

  // system clock and the microsecond tick derived from it
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS         = 1000;
  localparam int TICK_CYC      = US_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 7;

  // microsecond timer width, enough for the 100 ms windows
  localparam int TMR_W = 17;

  // timing figures, in microseconds (milliseconds times 1000)
  localparam int T_EARLY_WARN_US = 500;    // warning ahead of supply loss
  localparam int T_HOLD_US       = 500;    // sense held after warning
  localparam int T_PULSE_MIN_US  = 4;      // shortest warning pulse
  localparam int T_PULSE_MAX_US  = 1000;   // longest warning pulse
  localparam int T_RESTART_US    = 100000; // sense low before reassert
  localparam int T_REQ_DELAY_US  = 10000;  // request fall to warning
  localparam int T_RUSD33_MIN_US = 10000;  // 3.3 V start after core start
  localparam int T_RUSD33_MAX_US = 50000;
  localparam int T_RAMP_TOTAL_US = 100000; // all supplies up from core start

  // synchronised pin inputs
  localparam int SYNC_N    = 7;
  localparam int IN_REQ    = 0;
  localparam int IN_CLK_OK = 1;
  localparam int IN_LOSS   = 2;
  localparam int IN_G115   = 3;
  localparam int IN_G18    = 4;
  localparam int IN_G121   = 5;
  localparam int IN_G33    = 6;

  // sequencer states, gray from OFF up to ON and from ON through WARN down to REST, except the PWAIT to WARN step
  typedef enum logic [3:0] {
    PSQ_OFF   = 4'h0,
    PSQ_RAMP  = 4'h1,
    PSQ_CLKW  = 4'h3,
    PSQ_ON    = 4'h2,
    PSQ_PWAIT = 4'ha,
    PSQ_WARN  = 4'h6,
    PSQ_DN1   = 4'h7,
    PSQ_DN2   = 4'h5,
    PSQ_DN3   = 4'h4,
    PSQ_REST  = 4'hc
  } psq_state_t;

endpackage : psq_pkg

// *** design/psq_tick.sv ***
// one-cycle enable pulse every microsecond
// assumes the system clock given by the package constants
`timescale 1ns/1ps
`default_nettype none
module psq_tick
  import psq_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // enable out
  output logic      tick_us
);

  logic [TICK_W-1:0] cnt_q;
  wire               wrap = (cnt_q == TICK_W'(TICK_CYC - 1));

  // free-running divider
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + TICK_W'(1);
    end
  end

  assign tick_us = wrap;

endmodule : psq_tick
`default_nettype wire

// *** design/psq_sequencer.sv ***
// supply and reset sequencer driving a display controller's power pins
// assumes supply regulators report reaching 80% of typical voltage on pins
// Rules for the controller's power and clock pins
// - supply-good drops at least 500 us before any supply is turned off.
// - power-on sense stays high at least 500 us after supply-good drops.
// - a supply-good low pulse under raised sense lasts 4 to 1000 us.
// - once sense falls with supply-good low, it stays low 100 ms or more.
// - supply-good falls no sooner than 10 ms after the request falls; a supply loss during that wait drops it at once.
// - the primary reference clock is stable before sense rises.
// - the 3.3 V ramp starts 10 to 50 ms after the core ramp starts.
// - all four supplies finish ramping within 100 ms of the core start.
// - the reference clocks are not spread-spectrum.
// - one oscillator feeds the primary clock of every controller.
// - primary reference runs at 40 MHz and secondary at 38 MHz.
// - a request-driven shutdown need not keep the sense hold time.
// - the 1.8 V ramp starts only after the core supply reaches 80%.
// - the pulse upper limit holds only while the 1.8 V supply stays on.
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer
  import psq_pkg::*;
#(
  parameter int HOLD_US    = psq_pkg::T_HOLD_US,
  parameter int RESTART_US = psq_pkg::T_RESTART_US,
  parameter int REQ_DLY_US = psq_pkg::T_REQ_DELAY_US,
  parameter int RUSD33_US  = psq_pkg::T_RUSD33_MIN_US,
  parameter int RAMP_MAX_US = psq_pkg::T_RAMP_TOTAL_US
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // system request and status pins
  input  wire logic projector_on_request,
  input  wire logic ref_clock_stable,
  input  wire logic supply_loss_detect,
  // regulator 80% good pins
  input  wire logic good_1v15,
  input  wire logic good_1v8,
  input  wire logic good_1v21,
  input  wire logic good_3v3,
  // regulator enables
  output logic      en_1v15,
  output logic      en_1v8,
  output logic      en_1v21,
  output logic      en_3v3,
  // oscillator enable
  output logic      osc_enable,
  // controller reset pins
  output logic      power_on_sense,
  output logic      supply_good_warning,
  // status
  output logic      ramp_fault
);

  localparam logic [TMR_W-1:0] TMR_MAX = '1;

  logic [SYNC_N-1:0] meta_q;
  logic [SYNC_N-1:0] sync_q;
  psq_state_t        state_q, state_d;
  logic [TMR_W-1:0]  timer_q;
  logic              fault_q;
  logic              by_req_q;
  logic              tick_us;
  logic [3:0]        en_q;

  // raw pins gathered in input index order
  wire [SYNC_N-1:0] pin_raw = {good_3v3, good_1v21, good_1v8, good_1v15,
                               supply_loss_detect, ref_clock_stable,
                               projector_on_request};

  // all pins are asynchronous: two flops each, only the second is read
  for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pin_raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  psq_tick u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tick_us (tick_us)
  );

  // named views of the synchronised inputs
  wire req_s   = sync_q[IN_REQ];
  wire clk_ok  = sync_q[IN_CLK_OK];
  wire loss_s  = sync_q[IN_LOSS];
  wire g115_s  = sync_q[IN_G115];
  wire g18_s   = sync_q[IN_G18];
  wire g121_s  = sync_q[IN_G121];
  wire g33_s   = sync_q[IN_G33];
  wire all_up  = g115_s & g18_s & g121_s & g33_s;

  // timer compares, widths fixed to the timer; strictly above n because the
  // first tick may land right after a restart and would cut a window short
  wire t_hold    = (timer_q > TMR_W'(HOLD_US));
  wire t_restart = (timer_q > TMR_W'(RESTART_US));
  wire t_reqdly  = (timer_q > TMR_W'(REQ_DLY_US));
  wire t_33      = (timer_q > TMR_W'(RUSD33_US));
  wire t_rampto  = (timer_q > TMR_W'(RAMP_MAX_US));

  // next-state decode
  always_comb begin
    state_d = state_q;
    case (state_q)
      PSQ_OFF:   if (req_s) state_d = PSQ_RAMP;
      PSQ_RAMP: begin
        if (!req_s || t_rampto) state_d = PSQ_DN1;
        else if (all_up && en_q[3]) state_d = PSQ_CLKW;
      end
      PSQ_CLKW: begin
        if (!req_s || !all_up) state_d = PSQ_DN1;
        else if (clk_ok) state_d = PSQ_ON;
      end
      PSQ_ON: begin
        if (loss_s) state_d = PSQ_WARN;
        else if (!req_s) state_d = PSQ_PWAIT;
      end
      PSQ_PWAIT: begin
        if (loss_s || t_reqdly) state_d = PSQ_WARN;
      end
      PSQ_WARN:  if (t_hold) state_d = PSQ_DN1;
      PSQ_DN1:   if (!g121_s) state_d = PSQ_DN2;
      PSQ_DN2:   if (!g33_s && !g18_s) state_d = PSQ_DN3;
      PSQ_DN3:   state_d = PSQ_REST;
      PSQ_REST:  if (t_restart && !req_s) state_d = PSQ_OFF;
      default:   state_d = PSQ_OFF;
    endcase
  end

  // state, timer restarts on every state change
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PSQ_OFF;
      timer_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) timer_q <= '0;
      else if (tick_us && timer_q != TMR_MAX) timer_q <= timer_q + TMR_W'(1);
    end
  end

  // supply enables, order 1.15 -> 1.8 -> 1.21 and 1.15 -> 3.3; down reversed
  logic [3:0] en_d;
  always_comb begin
    en_d = en_q;
    case (state_q)
      PSQ_OFF:  en_d = 4'h0;
      PSQ_RAMP: begin
        en_d[0] = 1'b1;
        if (g115_s) en_d[1] = 1'b1;
        if (g18_s)  en_d[2] = 1'b1;
        if (t_33)   en_d[3] = 1'b1;
      end
      PSQ_DN1:  begin
        en_d[2] = 1'b0;
        en_d[3] = 1'b0;
      end
      PSQ_DN2:  if (!g121_s) en_d[1] = 1'b0;
      PSQ_DN3:  en_d[0] = 1'b0;
      default:  en_d = en_q;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) en_q <= 4'h0;
    else          en_q <= en_d;
  end

  // fault held until the next start; shutdown cause sampled while on, held until the next on
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_q  <= 1'b0;
      by_req_q <= 1'b0;
    end else begin
      if (state_q == PSQ_OFF && req_s) fault_q <= 1'b0;
      else if (state_q == PSQ_RAMP && t_rampto && req_s) fault_q <= 1'b1;
      if (state_q == PSQ_ON) by_req_q <= !loss_s;
    end
  end

  // sense and warning come straight from the state register
  assign power_on_sense      = (state_q == PSQ_ON) || (state_q == PSQ_PWAIT) ||
                               (state_q == PSQ_WARN);
  assign supply_good_warning = (state_q == PSQ_ON) || (state_q == PSQ_PWAIT);
  assign {en_3v3, en_1v21, en_1v8, en_1v15} = en_q;
  // clock runs from the first ramp so it settles before sense rises
  assign osc_enable = (en_q != 4'h0);
  assign ramp_fault = fault_q;

  // ---------------------------------------------------------------
  // assertions and helper counters, all in microseconds
  logic [TMR_W-1:0] pg_low_us_q;
  logic [TMR_W-1:0] ps_low_us_q;
  logic [TMR_W-1:0] req_low_us_q;
  logic [TMR_W-1:0] up_us_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_low_us_q  <= '0;
      ps_low_us_q  <= TMR_MAX;
      req_low_us_q <= '0;
      up_us_q      <= '0;
    end else begin
      if (supply_good_warning) pg_low_us_q <= '0;
      else if (tick_us && pg_low_us_q != TMR_MAX) pg_low_us_q <= pg_low_us_q + TMR_W'(1);
      if (power_on_sense) ps_low_us_q <= '0;
      else if (tick_us && ps_low_us_q != TMR_MAX) ps_low_us_q <= ps_low_us_q + TMR_W'(1);
      if (req_s) req_low_us_q <= '0;
      else if (tick_us && req_low_us_q != TMR_MAX) req_low_us_q <= req_low_us_q + TMR_W'(1);
      if (!en_q[0]) up_us_q <= '0;
      else if (tick_us && up_us_q != TMR_MAX) up_us_q <= up_us_q + TMR_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence warn_fell_s;
    $fell(supply_good_warning) ##1 power_on_sense;
  endsequence

  early_warning_a: assert property (($fell(en_3v3) || $fell(en_1v21)) |->
    !supply_good_warning && pg_low_us_q >= TMR_W'(T_EARLY_WARN_US))
    else $error("supply dropped without early warning");
  sense_hold_a: assert property ($fell(power_on_sense) |->
    $past(pg_low_us_q) >= TMR_W'(HOLD_US))
    else $error("sense released too soon after warning");
  pulse_width_a: assert property ($fell(power_on_sense) |->
    $past(pg_low_us_q) >= TMR_W'(T_PULSE_MIN_US) &&
    $past(pg_low_us_q) <= TMR_W'(T_PULSE_MAX_US))
    else $error("warning pulse width out of range");
  warn_seq_a: assert property (warn_fell_s |-> !supply_good_warning [*4])
    else $error("warning pulse returned high under sense");
  restart_gap_a: assert property ($rose(power_on_sense) |->
    $past(ps_low_us_q) >= TMR_W'(RESTART_US))
    else $error("sense reasserted before restart gap");
  request_delay_a: assert property ($fell(supply_good_warning) && by_req_q &&
    !$past(loss_s) |-> $past(req_low_us_q) >= TMR_W'(REQ_DLY_US))
    else $error("warning fell too soon after request");
  clock_first_a: assert property ($rose(power_on_sense) |-> $past(clk_ok))
    else $error("sense rose without stable clock");
  rail33_start_a: assert property ($rose(en_3v3) |->
    up_us_q >= TMR_W'(RUSD33_US) && up_us_q <= TMR_W'(T_RUSD33_MAX_US))
    else $error("3.3 V start outside window");
  ramp_total_a: assert property ($rose(power_on_sense) |->
    $past(up_us_q) <= TMR_W'(RAMP_MAX_US) + TMR_W'(1))
    else $error("sense rose after ramp deadline");
  core_first_a: assert property ($rose(en_1v8) |-> $past(g115_s))
    else $error("1.8 V enabled before core good");
  ready_first_a: assert property (power_on_sense |-> en_q == 4'hf)
    else $error("sense high with a supply off");

endmodule : psq_sequencer
`default_nettype wire

// *** bench/psq_supply_model.sv ***
// regulator and oscillator stand-in for the sequencer bench
// assumes enables come from the sequencer on the bench clock
`timescale 1ns/1ps
`default_nettype none
module psq_supply_model (
  // clock
  input  wire logic        clk,
  // enables and stuck controls, bit 4 is the oscillator
  input  wire logic [4:0]  en,
  input  wire logic [4:0]  stuck,
  input  wire logic [15:0] dly,
  // good pins, bit 4 is clock stable
  output logic      [4:0]  good
);
  logic [15:0] cnt_q [5];
  logic [4:0]  target;

  initial good = 5'h00;
  assign target = en & ~stuck;
  // each pin follows its enable dly+1 cycles later, both ways; a stuck pin never rises
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (good[i] == target[i]) begin
        cnt_q[i] <= 16'h0000;
      end else if (cnt_q[i] >= dly) begin
        good[i] <= target[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 16'h0001;
      end
    end
  end
endmodule : psq_supply_model
`default_nettype wire

// *** bench/test_psq_sequencer.sv ***
// self-checking bench for the power and reset sequencer
// assumes the supply model answers enables; inputs move 1 ns after edges
`timescale 1ns/1ps
`default_nettype none
module test_psq_sequencer;
  import psq_pkg::*;
  localparam int RST_US = 20;
  localparam int RMP_US = 50;
  logic        clk, reset_n, req, loss, sense_q;
  logic [4:0]  stuck, good;
  logic [15:0] dly;
  wire  [4:0]  en;
  wire         sense, warn, fault;
  wire  [7:0]  obs = {fault, warn, sense, en};
  int          miscompares = 0, compares = 0, ups = 0, v07 = 0, v14 = 0, n, m, gap;

  psq_sequencer #(.HOLD_US(T_HOLD_US), .RESTART_US(RST_US), .REQ_DLY_US(10),
    .RUSD33_US(10), .RAMP_MAX_US(RMP_US)) dut (
    .clk(clk), .reset_n(reset_n), .projector_on_request(req),
    .ref_clock_stable(good[4]), .supply_loss_detect(loss), .good_1v15(good[0]),
    .good_1v8(good[1]), .good_1v21(good[2]), .good_3v3(good[3]), .en_1v15(en[0]),
    .en_1v8(en[1]), .en_1v21(en[2]), .en_3v3(en[3]), .osc_enable(en[4]),
    .power_on_sense(sense), .supply_good_warning(warn), .ramp_fault(fault));
  psq_supply_model model (.clk(clk), .en(en), .stuck(stuck), .dly(dly), .good(good));

  function automatic int us_cyc(input int us);
    return us * TICK_CYC;
  endfunction : us_cyc

  task automatic check(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // count edges until an observed bit takes a value, bounded by lim
  task automatic wait_for(input int sel, input logic val, input int lim, output int cnt);
    cnt = 0;
    while (obs[sel] !== val && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask : wait_for

  task automatic power_up();
    int a;
    dly = 16'(1 + $urandom % 300);
    req = 1'b1;
    wait_for(0, 1'b1, us_cyc(2), a);
    wait_for(3, 1'b1, us_cyc(20), a);
    check(a >= us_cyc(10) - 1 && a <= us_cyc(11) + 8, a, us_cyc(10));
    wait_for(5, 1'b1, us_cyc(60), a);
    check(warn === 1'b1 && en === 5'h1f, 32'({warn, en}), 32'h3f);
    check(warn === sense, 32'(warn), 32'(sense));
    $display("test power-up done");
  endtask : power_up

  task automatic finish_test();
    $display("counts: compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // sense rises and enable order watched on every edge
  always @(posedge clk) begin
    sense_q <= sense;
    if (reset_n && sense && !sense_q) begin
      ups <= ups + 1;
      if (!good[4]) v07 <= v07 + 1;
    end
    if (reset_n && en[1] && !good[0]) v14 <= v14 + 1;
  end

  // hang guard sized above the longest expected run
  initial begin
    #(8 * 110000);
    miscompares++;
    finish_test();
  end

  initial begin
    reset_n = 1'b0; req = 1'b0; loss = 1'b0; stuck = 5'h00; dly = 16'h0010;
    void'($urandom(32'hbccdb642));
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    check(obs === 8'h00, 32'(obs), 32'h0);
    $display("test reset done");
    power_up();
    // shutdown by request, then restart; a request raised at once is toggled, as REST waits for it to drop
    req = 1'b0;
    wait_for(6, 1'b0, us_cyc(20), n);
    check(n >= us_cyc(10), n, us_cyc(10));
    wait_for(5, 1'b0, us_cyc(600), m);
    check(m >= us_cyc(T_HOLD_US), m, us_cyc(T_HOLD_US));
    wait_for(3, 1'b0, 8, n);
    check(n + m >= us_cyc(T_EARLY_WARN_US), n + m, us_cyc(T_EARLY_WARN_US));
    wait_for(0, 1'b0, us_cyc(50), gap);
    gap += n;
    req = 1'b1;
    wait_for(0, 1'b1, us_cyc(30), m);
    gap += m;
    if (en[0] !== 1'b1) begin
      req = 1'b0;
      repeat (4) @(posedge clk);
      #1 req = 1'b1;
      wait_for(0, 1'b1, us_cyc(30), m);
    end
    check(gap >= us_cyc(RST_US), gap, us_cyc(RST_US));
    $display("test shutdown done");
    // request withdrawn in mid-ramp: no sense pulse
    repeat (1 + $urandom % 100) @(posedge clk);
    #1 req = 1'b0;
    wait_for(0, 1'b0, us_cyc(10), n);
    check(obs === 8'h00, 32'(obs), 32'h0);
    check(ups === 1, ups, 1);
    $display("test abort done");
    // stuck rail: ramp times out
    repeat (us_cyc(RST_US + 5)) @(posedge clk);
    #1 stuck = 5'h04;
    req = 1'b1;
    wait_for(0, 1'b1, us_cyc(2), n);
    wait_for(7, 1'b1, us_cyc(RMP_US + 5), n);
    check(n >= us_cyc(RMP_US) - 1 && n <= us_cyc(RMP_US + 2), n, us_cyc(RMP_US));
    check(sense === 1'b0, 32'(sense), 32'h0);
    req = 1'b0;
    stuck = 5'h00;
    wait_for(0, 1'b0, us_cyc(10), n);
    $display("test ramp fault done");
    repeat (us_cyc(RST_US + 5)) @(posedge clk);
    #1 power_up();
    check(fault === 1'b0, 32'(fault), 32'h0);
    check(v07 === 0, v07, 0);
    check(v14 === 0, v14, 0);
    // supply loss while on: warning drops three edges later, sense still held
    loss = 1'b1;
    wait_for(6, 1'b0, 8, n);
    check(n == 3 && sense === 1'b1, 32'(n), 32'h3);
    $display("test supply loss done");
    finish_test();
  end
endmodule : test_psq_sequencer
`default_nettype wire
